// file: inc/por_seq_pkg.sv
// constants, register map and state codes for the power-on reset sequencer
package por_seq_pkg;
   localparam int CNT_W = 13;
   localparam int CFG_PINS_W = 14;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // counts of input clock periods
   localparam logic [CNT_W-1:0] POR_MIN_TICKS = 13'h0010;
   localparam logic [CNT_W-1:0] STRETCH_TICKS = 13'h0400;
   // counts of reference clock periods
   localparam logic [CNT_W-1:0] LOCK_TICKS = 13'h1900;
   localparam logic [CNT_W-1:0] HARD_TICKS = 13'h0200;
   localparam logic [CNT_W-1:0] SOFT_TICKS = 13'h0203;

   // pclk periods per input clock period (200 MHz / 4 = 50 MHz)
   localparam int IN_DIV = 4;

   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_PINS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_RSTCFG = 8'h0c;

   // ctrl fields
   localparam int CTRL_RDF_BIT = 0;
   localparam logic CTRL_RDF_RESET = 1'h0;

   // status fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_LOCKED_BIT = 6;
   localparam int ST_INT_POR_BIT = 7;
   localparam int ST_HARD_BIT = 8;
   localparam int ST_SOFT_BIT = 9;
   localparam int ST_SHORT_BIT = 10;
   localparam int ST_CFGWR_BIT = 11;

   localparam logic [DATA_W-1:0] RSTCFG_RESET = 32'h0000_0000;

   typedef enum logic [5:0] {
      S_PORIN   = 6'h01,
      S_STRETCH = 6'h02,
      S_LOCK    = 6'h04,
      S_HARD    = 6'h08,
      S_SOFT    = 6'h10,
      S_RUN     = 6'h20
   } seq_state_t;
endpackage

// file: inc/tick_if.sv
// enable ticks for the input clock and reference clock rates
`timescale 1ns/1ps
interface tick_if;
   logic in_tick;
   logic ref_tick;
   logic rdf_two;
   modport gen (output in_tick, output ref_tick, input rdf_two);
   modport use_side (input in_tick, input ref_tick, output rdf_two);
endinterface

// file: rtl/tick_divider.sv
// divider making input clock and reference clock enable pulses from pclk
`timescale 1ns/1ps
module tick_divider #(
   parameter int IN_DIV = por_seq_pkg::IN_DIV
)(
   input wire logic pclk,
   input wire logic presetn,
   tick_if.gen ticks
);
   localparam int DW = (IN_DIV > 1) ? $clog2(IN_DIV) : 1;
   localparam logic [DW-1:0] DIV_LAST = DW'(IN_DIV - 1);

   logic [DW-1:0] div_r;
   logic [DW-1:0] div_nxt;
   logic phase_r;
   logic in_tick_r;
   logic ref_tick_r;
   wire div_wrap = (div_r == DIV_LAST);

   assign div_nxt = div_wrap ? '0 : div_r + DW'(1);
   assign ticks.in_tick = in_tick_r;
   assign ticks.ref_tick = ref_tick_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_r <= '0;
         phase_r <= 1'b0;
         in_tick_r <= 1'b0;
         ref_tick_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         in_tick_r <= div_wrap;
         // divide factor 2 passes every second input tick
         ref_tick_r <= div_wrap && (!ticks.rdf_two || phase_r);
         if (div_wrap)
            phase_r <= ~phase_r;
      end
   end
endmodule

// file: rtl/power_on_reset_sequencer.sv
// power-on reset sequencer with apb registers and config capture
//
// Contract
// RL1: the board holds the power-on reset input low at least 16 input clocks.
// RL2: internal power-on reset stays asserted 1024 input clocks after release.
// RL3: pll lock comes 6400 reference periods (input clock / 1 or 2) later.
// RL4: hard reset is released 512 reference periods after pll lock.
// RL5: soft reset is released 515 reference periods after pll lock.
// RL6: config pins are held stable by the board and sampled at por release.
// RL7: a host may write the reset config word by slave port or system bus.
// RL8: all resets stay asserted while the power-on reset input is low.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module power_on_reset_sequencer #(
   parameter int IN_DIV = por_seq_pkg::IN_DIV,
   parameter logic [12:0] POR_MIN_TICKS = por_seq_pkg::POR_MIN_TICKS,
   parameter logic [12:0] STRETCH_TICKS = por_seq_pkg::STRETCH_TICKS,
   parameter logic [12:0] LOCK_TICKS = por_seq_pkg::LOCK_TICKS,
   parameter logic [12:0] HARD_TICKS = por_seq_pkg::HARD_TICKS,
   parameter logic [12:0] SOFT_TICKS = por_seq_pkg::SOFT_TICKS
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_on_reset_in_n,
   input wire logic config_source_select,
   input wire logic config_select,
   input wire logic slave_port_sync_select,
   input wire logic slave_port_wide_select,
   input wire logic [3:0] chip_identifier_pins,
   input wire logic [2:0] bus_mode_pins,
   input wire logic soft_watchdog_enable_pin,
   input wire logic [1:0] clock_mode_pins,
   input wire logic host_cfg_wr,
   input wire logic [31:0] host_cfg_data,
   output logic int_por_out_n,
   output logic system_pll_locked,
   output logic hard_reset_out_n,
   output logic soft_reset_out_n,
   output logic [31:0] reset_config_word,
   output logic [13:0] sampled_config
);
   tick_if ticks ();

   tick_divider #(
      .IN_DIV(IN_DIV)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .ticks(ticks.gen)
   );

   por_seq_pkg::seq_state_t state_r;
   por_seq_pkg::seq_state_t state_nxt;
   logic [12:0] cnt_r;
   logic [12:0] cnt_nxt;
   logic por_d_r;
   logic rdf_two_r;
   logic por_short_r;
   logic cfg_written_r;
   logic [31:0] cfg_word_r;
   logic [13:0] pins_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic int_por_n_r;
   logic locked_r;
   logic hard_n_r;
   logic soft_n_r;

   assign ticks.rdf_two = rdf_two_r;

   // sequence control
   wire por_low = !power_on_reset_in_n;
   wire por_rise = power_on_reset_in_n && !por_d_r;
   wire in_phase = (state_r == por_seq_pkg::S_PORIN) ||
                   (state_r == por_seq_pkg::S_STRETCH);
   wire tick = in_phase ? ticks.in_tick : ticks.ref_tick;
   wire stretch_done = (cnt_r == STRETCH_TICKS - 13'h0001); // RL2
   wire lock_done = (cnt_r == LOCK_TICKS - 13'h0001); // RL3
   wire hard_done = (cnt_r == HARD_TICKS - 13'h0001); // RL4
   wire soft_done = (cnt_r == SOFT_TICKS - 13'h0001); // RL5
   // the soft count runs on from the hard count, so it keeps the same origin
   wire keep_cnt = (state_r == por_seq_pkg::S_HARD) &&
                   (state_nxt == por_seq_pkg::S_SOFT);
   wire cnt_clear = (state_nxt != state_r) && !keep_cnt;
   wire cnt_sat = (state_r == por_seq_pkg::S_PORIN) &&
                  (cnt_r >= POR_MIN_TICKS);
   // a release before the minimum hold is flagged for software
   wire short_set = (state_r == por_seq_pkg::S_PORIN) && por_rise &&
                    (cnt_r < POR_MIN_TICKS); // RL1
   // host writes are taken between por release and hard reset release
   wire cfg_window = (state_r == por_seq_pkg::S_STRETCH) ||
                     (state_r == por_seq_pkg::S_LOCK) ||
                     (state_r == por_seq_pkg::S_HARD);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         por_seq_pkg::S_PORIN:
            if (power_on_reset_in_n)
               state_nxt = por_seq_pkg::S_STRETCH;
         por_seq_pkg::S_STRETCH:
            if (tick && stretch_done)
               state_nxt = por_seq_pkg::S_LOCK; // RL2
         por_seq_pkg::S_LOCK:
            if (tick && lock_done)
               state_nxt = por_seq_pkg::S_HARD; // RL3
         por_seq_pkg::S_HARD:
            if (tick && hard_done)
               state_nxt = por_seq_pkg::S_SOFT; // RL4
         por_seq_pkg::S_SOFT:
            if (tick && soft_done)
               state_nxt = por_seq_pkg::S_RUN; // RL5
         por_seq_pkg::S_RUN:
            state_nxt = por_seq_pkg::S_RUN;
         default:
            state_nxt = por_seq_pkg::S_PORIN;
      endcase
      if (por_low)
         state_nxt = por_seq_pkg::S_PORIN; // RL8
   end

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (cnt_clear)
         cnt_nxt = '0;
      else if (tick && !cnt_sat)
         cnt_nxt = cnt_r + 13'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= por_seq_pkg::S_PORIN;
         cnt_r <= '0;
         por_d_r <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         por_d_r <= power_on_reset_in_n;
      end
   end

   // reset outputs follow the next state so they change with it
   wire nxt_int_por_n = !((state_nxt == por_seq_pkg::S_PORIN) ||
                          (state_nxt == por_seq_pkg::S_STRETCH));
   wire nxt_locked = (state_nxt == por_seq_pkg::S_HARD) ||
                     (state_nxt == por_seq_pkg::S_SOFT) ||
                     (state_nxt == por_seq_pkg::S_RUN);
   wire nxt_hard_n = (state_nxt == por_seq_pkg::S_SOFT) ||
                     (state_nxt == por_seq_pkg::S_RUN);
   wire nxt_soft_n = (state_nxt == por_seq_pkg::S_RUN);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_por_n_r <= 1'b0;
         locked_r <= 1'b0;
         hard_n_r <= 1'b0;
         soft_n_r <= 1'b0;
      end
      else
      begin
         int_por_n_r <= nxt_int_por_n; // RL2
         locked_r <= nxt_locked; // RL3
         hard_n_r <= nxt_hard_n; // RL4
         soft_n_r <= nxt_soft_n; // RL5
      end
   end

   // config pins caught at the edge where por input is seen released
   wire [13:0] pins_now = {clock_mode_pins, soft_watchdog_enable_pin,
                           bus_mode_pins, chip_identifier_pins,
                           slave_port_wide_select, slave_port_sync_select,
                           config_select, config_source_select};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pins_r <= '0;
      else if (state_r == por_seq_pkg::S_PORIN && por_rise)
         pins_r <= pins_now; // RL6
   end

   // apb decode
   wire apb_setup = psel && !penable;
   wire apb_access = psel && penable;
   wire apb_done = apb_access && pready_r;
   wire sel_ctrl = (paddr == por_seq_pkg::ADDR_CTRL);
   wire sel_status = (paddr == por_seq_pkg::ADDR_STATUS);
   wire sel_pins = (paddr == por_seq_pkg::ADDR_PINS);
   wire sel_rstcfg = (paddr == por_seq_pkg::ADDR_RSTCFG);
   wire sel_hit = sel_ctrl || sel_status || sel_pins || sel_rstcfg;
   wire wr_ctrl = apb_done && pwrite && sel_ctrl;
   wire wr_status = apb_done && pwrite && sel_status;
   wire wr_bus_cfg = apb_done && pwrite && sel_rstcfg && cfg_window;
   wire wr_port_cfg = host_cfg_wr && cfg_window;
   wire short_clr = wr_status && pwdata[por_seq_pkg::ST_SHORT_BIT];
   wire cfgwr_clr = wr_status && pwdata[por_seq_pkg::ST_CFGWR_BIT];

   wire [31:0] status_word = {20'h0_0000, cfg_written_r, por_short_r,
                              soft_n_r, hard_n_r, int_por_n_r, locked_r,
                              state_r};
   wire [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, rdf_two_r} :
                        sel_status ? status_word :
                        sel_pins ? {18'h0_0000, pins_r} :
                        sel_rstcfg ? cfg_word_r : 32'h0000_0000;

   // answer one cycle into the access phase so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end
      else
      begin
         pready_r <= apb_access && !pready_r;
         pslverr_r <= apb_access && !pready_r && !sel_hit;
         if (apb_access && !pready_r && !pwrite)
            prdata_r <= rd_mux;
         else if (apb_setup)
            prdata_r <= '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdf_two_r <= por_seq_pkg::CTRL_RDF_RESET;
      else if (wr_ctrl)
         rdf_two_r <= pwdata[por_seq_pkg::CTRL_RDF_BIT]; // RL3
   end

   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         por_short_r <= 1'b0;
         cfg_written_r <= 1'b0;
      end
      else
      begin
         por_short_r <= short_set || (por_short_r && !short_clr); // RL1
         cfg_written_r <= wr_bus_cfg || wr_port_cfg ||
                          (cfg_written_r && !cfgwr_clr);
      end
   end

   // slave port wins over the bus when both write in one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_word_r <= por_seq_pkg::RSTCFG_RESET;
      else if (wr_port_cfg)
         cfg_word_r <= host_cfg_data; // RL7
      else if (wr_bus_cfg)
         cfg_word_r <= pwdata; // RL7
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign int_por_out_n = int_por_n_r;
   assign system_pll_locked = locked_r;
   assign hard_reset_out_n = hard_n_r;
   assign soft_reset_out_n = soft_n_r;
   assign reset_config_word = cfg_word_r;
   assign sampled_config = pins_r;
endmodule

// file: test/por_seq_sva.sv
// port-level checks for the power-on reset sequencer
`timescale 1ns/1ps
module por_seq_sva #(
   parameter int IN_DIV = 4,
   parameter logic [12:0] STRETCH_TICKS = 13'h0400,
   parameter logic [12:0] LOCK_TICKS = 13'h1900,
   parameter logic [12:0] HARD_TICKS = 13'h0200,
   parameter logic [12:0] SOFT_TICKS = 13'h0203
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic power_on_reset_in_n,
   input wire logic int_por_out_n,
   input wire logic system_pll_locked,
   input wire logic hard_reset_out_n,
   input wire logic soft_reset_out_n
);
   // windows cover the free-running tick phase and a divide factor of two
   localparam int ST_LO = STRETCH_TICKS * IN_DIV - IN_DIV - 2;
   localparam int ST_W = IN_DIV + 4;
   localparam int LK_LO = LOCK_TICKS * IN_DIV - IN_DIV - 2;
   localparam int LK_W = LOCK_TICKS * IN_DIV + IN_DIV + 6;
   localparam int HD_LO = HARD_TICKS * IN_DIV - 1;
   localparam int HD_W = HARD_TICKS * IN_DIV + 2;
   localparam int SG_LO = (SOFT_TICKS - HARD_TICKS) * IN_DIV - 1;
   localparam int SG_W = (SOFT_TICKS - HARD_TICKS) * IN_DIV + 2;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   all_held_a: assert property (!power_on_reset_in_n |=>
      !int_por_out_n && !hard_reset_out_n && !soft_reset_out_n)
      else $error("resets not held");
   por_stretch_a: assert property ($rose(power_on_reset_in_n) |->
      ##ST_LO !int_por_out_n ##[1:ST_W] int_por_out_n)
      else $error("internal reset release off");
   pll_lock_a: assert property ($rose(int_por_out_n) |->
      ##LK_LO !system_pll_locked ##[1:LK_W] system_pll_locked)
      else $error("lock time off");
   hard_time_a: assert property ($rose(system_pll_locked) |->
      ##HD_LO !hard_reset_out_n ##[1:HD_W] hard_reset_out_n)
      else $error("hard reset time off");
   soft_gap_a: assert property ($rose(hard_reset_out_n) |->
      ##SG_LO !soft_reset_out_n ##[1:SG_W] soft_reset_out_n)
      else $error("soft reset time off");
   release_order_a: assert property (soft_reset_out_n |->
      hard_reset_out_n && system_pll_locked && int_por_out_n)
      else $error("release order broken");
   apb_wait_a: assert property ($rose(penable) && psel |->
      !pready ##1 pready) else $error("apb wait state off");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   // read data is held after the answer and cleared by the next setup
   rdata_idle_a: assert property (psel && !penable |=>
      prdata == 32'h0000_0000)
      else $error("read data not idle");
endmodule
bind power_on_reset_sequencer por_seq_sva #(.IN_DIV(IN_DIV),
   .STRETCH_TICKS(STRETCH_TICKS), .LOCK_TICKS(LOCK_TICKS),
   .HARD_TICKS(HARD_TICKS), .SOFT_TICKS(SOFT_TICKS)) i_por_seq_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .power_on_reset_in_n(power_on_reset_in_n),
   .int_por_out_n(int_por_out_n), .system_pll_locked(system_pll_locked),
   .hard_reset_out_n(hard_reset_out_n), .soft_reset_out_n(soft_reset_out_n));

// file: test/board_model.sv
// board side: power-on reset source, strap pins and slave-port host
`timescale 1ns/1ps
module board_model (
   input wire logic pclk,
   output logic por_n,
   output logic [13:0] straps,
   output logic host_cfg_wr,
   output logic [31:0] host_cfg_data
);
   initial
   begin
      por_n = 1'b0;
      straps = 14'h0000;
      host_cfg_wr = 1'b0;
      host_cfg_data = 32'h0000_0000;
   end
   // a low time below the minimum is only given when a test asks for it
   task automatic por_pulse(input int low, input logic [13:0] s);
      @(posedge pclk) por_n <= 1'b0;
      straps <= s;
      repeat (low) @(posedge pclk);
      por_n <= 1'b1;
      repeat (3) @(posedge pclk);
      straps <= ~s;
   endtask
   // data goes stale after the strobe so a late capture shows up
   task automatic cfg_write(input logic [31:0] d);
      @(posedge pclk) host_cfg_wr <= 1'b1;
      host_cfg_data <= d;
      @(posedge pclk) host_cfg_wr <= 1'b0;
      host_cfg_data <= ~d;
   endtask
endmodule

// file: test/power_on_reset_sequencer_bench.sv
// self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
module power_on_reset_sequencer_bench;
   // DIV matches the design's default input clock divider
   localparam int DIV = 4;
   localparam int HRD = 5;
   localparam int SFT = 8;
   localparam int LCK = 20;
   typedef struct packed
   {
      logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;
   } row_t;
   row_t rows [8] = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h00, 32'h1, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}, '{1'b1, 8'h0c, 32'h9, 32'h0, 1'b0},
      '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0}};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, por_n, host_cfg_wr, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, host_cfg_data, rcw, rd;
   logic [13:0] straps, cfg;
   logic int_n, lock, hard_n, soft_n;
   int n_mismatch = 0, compares = 0;
   always #2.5 pclk = ~pclk;
   power_on_reset_sequencer #(.STRETCH_TICKS(13'h0008),
      .LOCK_TICKS(13'h0014), .HARD_TICKS(13'h0005),
      .SOFT_TICKS(13'h0008))
   i_power_on_reset_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_on_reset_in_n(por_n), .config_source_select(straps[0]),
      .config_select(straps[1]), .slave_port_sync_select(straps[2]),
      .slave_port_wide_select(straps[3]), .chip_identifier_pins(straps[7:4]),
      .bus_mode_pins(straps[10:8]), .soft_watchdog_enable_pin(straps[11]),
      .clock_mode_pins(straps[13:12]), .host_cfg_wr(host_cfg_wr),
      .host_cfg_data(host_cfg_data), .int_por_out_n(int_n),
      .system_pll_locked(lock), .hard_reset_out_n(hard_n),
      .soft_reset_out_n(soft_n), .reset_config_word(rcw),
      .sampled_config(cfg));
   board_model i_board_model (.pclk(pclk), .por_n(por_n), .straps(straps),
      .host_cfg_wr(host_cfg_wr), .host_cfg_data(host_cfg_data));
   task automatic close_out;
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok);
      compares++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("Error at %0t: output mismatch", $time);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk) psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // edge counts between output releases; all but the internal por release land on reference ticks
   task automatic seq_check(input int pll_ref_divide_factor);
      int c;
      c = 0;
      while (int_n !== 1'b1) @(posedge pclk);
      while (lock !== 1'b1)
      begin
         @(posedge pclk);
         c++;
      end
      chk(c <= LCK * DIV * pll_ref_divide_factor && c > (LCK - 1) * DIV * pll_ref_divide_factor);
      c = 0;
      while (hard_n !== 1'b1)
      begin
         @(posedge pclk);
         c++;
      end
      chk(c == HRD * DIV * pll_ref_divide_factor);
      c = 0;
      while (soft_n !== 1'b1)
      begin
         @(posedge pclk);
         c++;
      end
      chk(c == (SFT - HRD) * DIV * pll_ref_divide_factor);
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk(rd === rows[i].q && er === rows[i].e);
      end
      i_board_model.por_pulse(80, 14'h2a5c);
      chk(cfg === 14'h2a5c);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd === 32'h0000_2a5c && er === 1'b0);
      i_board_model.cfg_write(32'hc0de_0001);
      @(posedge pclk);
      chk(rcw === 32'hc0de_0001);
      apb(1'b1, 8'h0c, 32'h5a5a_0002);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd === 32'h5a5a_0002);
      seq_check(2);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd === 32'h0000_0be0);
      i_board_model.cfg_write(32'h0000_0007);
      @(posedge pclk);
      chk(rcw === 32'h5a5a_0002);
      apb(1'b1, 8'h00, 32'h0);
      i_board_model.por_pulse(2, 14'h15a3);
      chk(cfg === 14'h15a3);
      seq_check(1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[10] === 1'b1);
      apb(1'b1, 8'h04, 32'h0000_0c00);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd === 32'h0000_03e0);
      // a reset in mid-run must bring back the reset values of the four reset outputs, the config word, the sampled pins and ctrl
      @(posedge pclk) presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({int_n, lock, hard_n, soft_n} === 4'h0 && rcw === 32'h0 &&
         cfg === 14'h0);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd === 32'h0 && er === 1'b0);
      close_out();
   end
   // the whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      close_out();
   end
endmodule
